// ===== core/fgd_input_divide_mask.sv
// tachometer input conditioning: doubler, dividers, mask timers, control regs
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fgd_input_divide_mask
   import fgd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       capstan_tach_input,
   input  wire logic       drum_tach_input,
   input  wire logic       drum_ref_pulse_input,
   output logic            capstan_divided_pulse,
   output logic            drum_divided_pulse
);

   typedef struct packed {
      fgd_in_s             cin;
      fgd_in_s             din;
      fgd_in_s             rin;
      fgd_chan_s           cap;
      fgd_chan_s           drm;
      logic [FGD_PRESCALE_W-1:0] prescale;
      logic                cap_msel;
      logic                drm_msel;
      logic                dbl;
      logic                inv;
      logic                ref_init;
      logic                ref_flag;
      logic [7:0]          cap_ratio;
      logic [3:0]          drm_ratio;
      logic [7:0]          cap_mask;
      logic [7:0]          drm_mask;
      logic [7:0]          rdata;
      logic                cap_out;
      logic                drm_out;
   } fgd_state_s;

   fgd_state_s st;
   fgd_state_s next_st;

   logic c_rise, c_fall, d_rise, d_fall, r_rise;
   logic c_raw, c_ev, d_ev, c_tick, d_tick, c_div, d_div;
   logic tap9, tap13;
   logic wr_cap_div, wr_drm_div;
   logic [7:0] drm_ratio8;

   // edge events compare the second stage with its own last value only
   assign c_rise = st.cin.sync[1] & ~st.cin.last;
   assign c_fall = ~st.cin.sync[1] & st.cin.last;
   // inversion swaps which edge counts as rising
   assign d_rise = st.inv ? (~st.din.sync[1] & st.din.last) : (st.din.sync[1] & ~st.din.last);
   assign d_fall = st.inv ? (st.din.sync[1] & ~st.din.last) : (~st.din.sync[1] & st.din.last);
   assign r_rise = st.rin.sync[1] & ~st.rin.last;

   // doubling treats both edges as rising events for the divider
   assign c_raw = st.dbl ? (c_rise | c_fall) : c_rise;
   // ratio zero takes both edges, with or without doubling
   assign c_ev = (st.cap_ratio == 8'h00) ? (c_rise | c_fall) : c_raw;
   assign d_ev = (st.drm_ratio == 4'h0) ? (d_rise | d_fall) : d_rise;

   // tick in the cycle before the selected prescaler bit falls
   // read from the register only, so no loop through next_st
   assign tap9  = &st.prescale[FGD_TAP_SLOW_BIT:0];
   assign tap13 = &st.prescale[FGD_TAP_SLOWER_BIT:0];
   assign c_tick = st.cap_msel ? tap13 : tap9;
   assign d_tick = st.drm_msel ? tap13 : tap9;

   assign wr_cap_div = wr && (addr == FGD_CAP_DIV_ADDR);
   assign wr_drm_div = wr && (addr == FGD_DRM_DIV_ADDR);
   assign drm_ratio8 = {4'h0, st.drm_ratio};

   // divider output when the counted edges reach the ratio
   assign c_div = c_ev && ((st.cap_ratio == 8'h00) || (st.cap.cnt + 8'h01 >= st.cap_ratio));
   assign d_div = d_ev && ((st.drm_ratio == 4'h0) || (st.drm.cnt + 8'h01 >= drm_ratio8));

   function automatic fgd_chan_s chan_step(input fgd_chan_s c, input logic ev, input logic div,
                                           input logic reload, input logic tick,
                                           input logic [7:0] mask_n, input logic clr,
                                           output logic pulse);
      fgd_chan_s n;
      logic      go;
      n = c;
      go = div && !reload;
      pulse = 1'b0;
      if (reload) begin
         n.cnt = 8'h00;
      end else if (ev) begin
         n.cnt = div ? 8'h00 : c.cnt + 8'h01;
      end
      if (c.masking && tick) begin
         n.mtmr = c.mtmr - 8'h01;
         if (c.mtmr <= 8'h01) begin
            n.masking = 1'b0;
         end
      end
      if (clr) begin
         n.flag = 1'b0;
      end
      if (go) begin
         if (c.masking) begin
            n.flag = 1'b1;
         end else begin
            pulse = 1'b1;
            if (mask_n != 8'h00) begin
               n.mtmr = mask_n;
               n.masking = 1'b1;
            end
         end
      end
      return n;
   endfunction

   always_comb begin
      logic cp;
      logic dp;
      cp = 1'b0;
      dp = 1'b0;
      next_st = st;
      next_st.cin.sync = {st.cin.sync[0], capstan_tach_input};
      next_st.din.sync = {st.din.sync[0], drum_tach_input};
      next_st.rin.sync = {st.rin.sync[0], drum_ref_pulse_input};
      next_st.cin.last = st.cin.sync[1];
      next_st.din.last = st.din.sync[1];
      next_st.rin.last = st.rin.sync[1];
      next_st.prescale = st.prescale + 14'h0001;

      next_st.cap = chan_step(st.cap, c_ev, c_div, wr_cap_div, c_tick, st.cap_mask,
                              wr && (addr == FGD_CAP_CTRL_ADDR) && !wdata[FGD_FLAG_CLR_BIT], cp);
      next_st.drm = chan_step(st.drm, d_ev, d_div, wr_drm_div || (st.ref_init && r_rise),
                              d_tick, st.drm_mask,
                              wr && (addr == FGD_DRM_CTRL_ADDR) && !wdata[FGD_FLAG_CLR_BIT], dp);
      next_st.cap_out = cp;
      next_st.drm_out = dp;

      if (wr && (addr == FGD_DRM_CTRL_ADDR) && !wdata[FGD_REF_CLR_BIT]) begin
         next_st.ref_flag = 1'b0;
      end
      if (r_rise) begin
         next_st.ref_flag = 1'b1;
      end

      if (wr) begin
         case (addr)
            FGD_CAP_CTRL_ADDR: begin
               next_st.cap_msel = wdata[FGD_MCLK_SEL_BIT];
               next_st.dbl      = wdata[FGD_DOUBLE_BIT];
            end
            FGD_DRM_CTRL_ADDR: begin
               next_st.drm_msel = wdata[FGD_MCLK_SEL_BIT];
               next_st.inv      = wdata[FGD_DRM_INV_BIT];
            end
            FGD_CAP_DIV_ADDR:  next_st.cap_ratio = wdata;
            FGD_DRM_DIV_ADDR:  next_st.drm_ratio = wdata[3:0];
            FGD_CAP_MASK_ADDR: next_st.cap_mask = wdata;
            FGD_DRM_MASK_ADDR: next_st.drm_mask = wdata;
            FGD_REF_INIT_ADDR: next_st.ref_init = wdata[FGD_REF_INIT_BIT];
            default: ;
         endcase
      end

      next_st.rdata = 8'h00;
      if (rd) begin
         case (addr)
            FGD_CAP_CTRL_ADDR: next_st.rdata = {st.cap.flag, 1'b1, st.cap.masking,
                                                st.cap_msel, 3'b000, st.dbl};
            FGD_DRM_CTRL_ADDR: next_st.rdata = {st.drm.flag, 1'b1, st.drm.masking,
                                                st.drm_msel, st.inv, st.ref_flag,
                                                1'b1, 1'b0};
            FGD_CAP_DIV_ADDR:  next_st.rdata = st.cap_ratio;
            FGD_DRM_DIV_ADDR:  next_st.rdata = {4'h0, st.drm_ratio};
            FGD_CAP_MASK_ADDR: next_st.rdata = st.cap_mask;
            FGD_DRM_MASK_ADDR: next_st.rdata = st.drm_mask;
            FGD_REF_INIT_ADDR: next_st.rdata = {7'h00, st.ref_init};
            default:           next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign capstan_divided_pulse = st.cap_out;
   assign drum_divided_pulse = st.drm_out;

   a_mask_blocks_out: assert property (@(posedge clk) disable iff (!rst_n)
      st.cap.masking |=> !capstan_divided_pulse)
      else $error("capstan pulse passed while masking");
   a_zero_mask_free: assert property (@(posedge clk) disable iff (!rst_n)
      (st.cap_mask == 8'h00 && !st.cap.masking) |=> !st.cap.masking)
      else $error("masking started with zero count");
   a_flag_on_masked: assert property (@(posedge clk) disable iff (!rst_n)
      (c_div && !wr_cap_div && st.cap.masking) |=> st.cap.flag)
      else $error("capstan masked edge flag not set");
   a_reload_kills: assert property (@(posedge clk) disable iff (!rst_n)
      wr_cap_div |=> !capstan_divided_pulse)
      else $error("pulse not suppressed on reload");
   a_ref_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      r_rise |=> st.ref_flag)
      else $error("reference flag not set");
   a_drum_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      (d_div && st.drm.masking && !(st.ref_init && r_rise) && !wr_drm_div) |=> st.drm.flag)
      else $error("drum masked edge flag not set");
   a_ratio_one_pass: assert property (@(posedge clk) disable iff (!rst_n)
      (c_ev && st.cap_ratio == 8'h01 && !st.cap.masking && !wr_cap_div)
      |=> capstan_divided_pulse)
      else $error("ratio one did not pass each edge");
   a_drum_init: assert property (@(posedge clk) disable iff (!rst_n)
      (st.ref_init && r_rise) |=> st.drm.cnt == 8'h00)
      else $error("drum divider not reset by reference edge");

   // divided edges that survive a reload; the checks below build on them
   logic cap_go;
   logic drm_go;
   assign cap_go = c_div && !wr_cap_div;
   assign drm_go = d_div && !wr_drm_div && !(st.ref_init && r_rise);

   sequence s_cap_open;
      cap_go && !st.cap.masking;
   endsequence
   sequence s_cap_arm;
      s_cap_open ##0 (st.cap_mask != 8'h00);
   endsequence
   sequence s_drm_open;
      drm_go && !st.drm.masking;
   endsequence
   sequence s_drm_arm;
      s_drm_open ##0 (st.drm_mask != 8'h00);
   endsequence
   sequence s_cap_last_tick;
      st.cap.masking && c_tick && (st.cap.mtmr <= 8'h01);
   endsequence
   sequence s_drm_last_tick;
      st.drm.masking && d_tick && (st.drm.mtmr <= 8'h01);
   endsequence

   a_cap_pass_edge: assert property (@(posedge clk) disable iff (!rst_n)
      s_cap_open |=> capstan_divided_pulse)
      else $error("capstan divided edge not passed");

   a_drum_pass_edge: assert property (@(posedge clk) disable iff (!rst_n)
      s_drm_open |=> drum_divided_pulse)
      else $error("drum divided edge not passed");

   a_cap_mask_load: assert property (@(posedge clk) disable iff (!rst_n)
      s_cap_arm |=> (st.cap.masking && st.cap.mtmr == $past(st.cap_mask)))
      else $error("capstan mask timer not loaded");

   a_drum_mask_load: assert property (@(posedge clk) disable iff (!rst_n)
      s_drm_arm |=> (st.drm.masking && st.drm.mtmr == $past(st.drm_mask)))
      else $error("drum mask timer not loaded");

   a_cap_timer_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (st.cap.masking && !c_tick) |=> (st.cap.mtmr == $past(st.cap.mtmr)))
      else $error("running capstan mask timer reloaded");

   a_drum_timer_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (st.drm.masking && !d_tick) |=> (st.drm.mtmr == $past(st.drm.mtmr)))
      else $error("running drum mask timer reloaded");

   a_cap_release: assert property (@(posedge clk) disable iff (!rst_n)
      s_cap_last_tick |=> !st.cap.masking)
      else $error("capstan mask not released");

   a_drum_release: assert property (@(posedge clk) disable iff (!rst_n)
      s_drm_last_tick |=> !st.drm.masking)
      else $error("drum mask not released");

   a_drum_blocks_out: assert property (@(posedge clk) disable iff (!rst_n)
      st.drm.masking |=> !drum_divided_pulse)
      else $error("drum pulse passed while masking");

   a_cap_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == FGD_CAP_CTRL_ADDR)
      |=> (rdata[FGD_MASK_STAT_BIT] == $past(st.cap.masking) && rdata[FGD_FLAG_CLR_BIT]))
      else $error("capstan control read wrong");

   a_drum_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == FGD_DRM_CTRL_ADDR)
      |=> (rdata[FGD_MASK_STAT_BIT] == $past(st.drm.masking) && rdata[FGD_REF_CLR_BIT]))
      else $error("drum control read wrong");

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !rd |=> (rdata == 8'h00))
      else $error("read data without a read");

   a_cap_flag_clr: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && addr == FGD_CAP_CTRL_ADDR && !wdata[FGD_FLAG_CLR_BIT] && !(cap_go && st.cap.masking))
      |=> !st.cap.flag)
      else $error("capstan flag not cleared");

   a_cap_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
      (st.cap.flag && !(wr && addr == FGD_CAP_CTRL_ADDR && !wdata[FGD_FLAG_CLR_BIT]))
      |=> st.cap.flag)
      else $error("capstan flag lost");

   a_drum_flag_clr: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && addr == FGD_DRM_CTRL_ADDR && !wdata[FGD_FLAG_CLR_BIT] && !(drm_go && st.drm.masking))
      |=> !st.drm.flag)
      else $error("drum flag not cleared");

   a_drum_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
      (st.drm.flag && !(wr && addr == FGD_DRM_CTRL_ADDR && !wdata[FGD_FLAG_CLR_BIT]))
      |=> st.drm.flag)
      else $error("drum flag lost");

   a_ref_flag_clr: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && addr == FGD_DRM_CTRL_ADDR && !wdata[FGD_REF_CLR_BIT] && !r_rise)
      |=> !st.ref_flag)
      else $error("reference flag not cleared");

   a_ref_flag_keep: assert property (@(posedge clk) disable iff (!rst_n)
      (st.ref_flag && !(wr && addr == FGD_DRM_CTRL_ADDR && !wdata[FGD_REF_CLR_BIT]))
      |=> st.ref_flag)
      else $error("reference flag lost");

   a_cap_one_event: assert property (@(posedge clk) disable iff (!rst_n)
      c_rise |=> !c_rise)
      else $error("capstan edge gave two events");

   a_ref_one_event: assert property (@(posedge clk) disable iff (!rst_n)
      r_rise |=> !r_rise)
      else $error("reference edge gave two events");
endmodule
`default_nettype wire

// ===== core/fgd_pkg.sv
// package for the tachometer input divide and mask block
package fgd_pkg;
   // register offsets (byte addresses on the plain port)
   localparam logic [7:0] FGD_CAP_CTRL_ADDR = 8'h52;
   localparam logic [7:0] FGD_CAP_DIV_ADDR  = 8'h53;
   localparam logic [7:0] FGD_DRM_CTRL_ADDR = 8'h56;
   localparam logic [7:0] FGD_DRM_DIV_ADDR  = 8'h54;
   localparam logic [7:0] FGD_DRM_MASK_ADDR = 8'h55;
   localparam logic [7:0] FGD_CAP_MASK_ADDR = 8'h58;
   localparam logic [7:0] FGD_REF_INIT_ADDR = 8'h57;
   // control bit positions
   localparam int FGD_EDGE_FLAG_BIT = 7;
   localparam int FGD_FLAG_CLR_BIT  = 6;
   localparam int FGD_MASK_STAT_BIT = 5;
   localparam int FGD_MCLK_SEL_BIT  = 4;
   localparam int FGD_DRM_INV_BIT   = 3;
   localparam int FGD_REF_FLAG_BIT  = 2;
   localparam int FGD_REF_CLR_BIT   = 1;
   localparam int FGD_DOUBLE_BIT    = 0;
   localparam int FGD_REF_INIT_BIT  = 0;
   // reset values
   localparam logic [7:0] FGD_RATIO_RST = 8'h00;
   localparam logic [7:0] FGD_MASK_RST  = 8'h00;
   // mask clock taps: system clock divided by 2^10 and 2^14
   localparam int FGD_TAP_SLOW_BIT   = 9;
   localparam int FGD_TAP_SLOWER_BIT = 13;
   localparam int FGD_PRESCALE_W     = 14;

   typedef struct packed {
      logic [1:0] sync;
      logic       last;
   } fgd_in_s;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] mtmr;
      logic       masking;
      logic       flag;
   } fgd_chan_s;
endpackage

// ===== tb/fgd_tach_model.sv
// tachometer sensor model: a burst of edges on the capstan and drum lines
`timescale 1ns/1ps
`default_nettype none
module fgd_tach_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [7:0]  n_edges,
   input  wire logic [15:0] half,
   output logic             busy,
   output logic             cap_tach,
   output logic             drm_tach
);
   logic [7:0]  left;
   logic [15:0] wait_cnt;
   initial begin
      busy = 1'b0;
      cap_tach = 1'b0;
      drm_tach = 1'b0;
      left = 8'h00;
      wait_cnt = 16'h0000;
   end
   // lines start low and toggle on each edge; an even burst lands back at the level it started from
   always @(posedge clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         left <= n_edges;
         wait_cnt <= half;
      end else if (busy) begin
         if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
         end else if (left == 8'h00) begin
            busy <= 1'b0;
         end else begin
            cap_tach <= !cap_tach;
            drm_tach <= !drm_tach;
            left <= left - 8'h01;
            wait_cnt <= half;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/test_fgd_input_divide_mask.sv
// self-checking bench for the tachometer divide and mask block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_fgd_input_divide_mask;
   import fgd_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ref_in = 1'b0, go = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, n_edges = 8'h00, rv;
   logic [15:0] half = 16'h0028;
   logic cap_t, drm_t, cap_p, drm_p, busy;
   int failures = 0, num_checks = 0, cap_n = 0, drm_n = 0;
   fgd_input_divide_mask i_fgd_input_divide_mask (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capstan_tach_input(cap_t),
      .drum_tach_input(drm_t), .drum_ref_pulse_input(ref_in),
      .capstan_divided_pulse(cap_p), .drum_divided_pulse(drm_p));
   fgd_tach_model i_fgd_tach_model (.clk(clk), .go(go), .n_edges(n_edges), .half(half),
      .busy(busy), .cap_tach(cap_t), .drm_tach(drm_t));
   initial begin
      forever #12.5 clk = !clk;
   end
   always @(posedge clk) begin
      cap_n += int'(cap_p);
      drm_n += int'(drm_p);
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK("register", e, rdata)
   endtask
   // burst of edges, then enough cycles for the three-cycle pulse latency
   task automatic burst(input logic [7:0] n, input int ec, input int ed);
      cap_n = 0; drm_n = 0;
      @(posedge clk);
      n_edges <= n; go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      // busy rises at the edge that takes go; look only after it has settled
      @(posedge clk);
      repeat (20000) if (busy === 1'b1) @(posedge clk);
      repeat (8) @(posedge clk);
      `CHK("capstan pulses", ec, cap_n)
      `CHK("drum pulses", ed, drm_n)
   endtask
   task automatic t_reset();
      rd_chk(FGD_CAP_CTRL_ADDR, 8'h40);
      rd_chk(FGD_DRM_CTRL_ADDR, 8'h42);
      rd_chk(FGD_CAP_DIV_ADDR, FGD_RATIO_RST);
      rd_chk(FGD_CAP_MASK_ADDR, FGD_MASK_RST);
      rd_chk(8'h60, 8'h00);
      wr_reg(FGD_CAP_CTRL_ADDR, 8'h50);
      rd_chk(FGD_CAP_CTRL_ADDR, 8'h50);
      wr_reg(FGD_CAP_CTRL_ADDR, 8'h40);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h52);
      rd_chk(FGD_DRM_CTRL_ADDR, 8'h52);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h42);
      $display("test reset done");
   endtask
   task automatic pulse_ref();
      @(posedge clk);
      ref_in <= 1'b1;
      repeat (8) @(posedge clk);
      ref_in <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic t_divide();
      burst(8'h06, 6, 6);
      wr_reg(FGD_CAP_DIV_ADDR, 8'h03);
      wr_reg(FGD_DRM_DIV_ADDR, 8'h02);
      rd_chk(FGD_CAP_DIV_ADDR, 8'h03);
      burst(8'h0c, 2, 3);
      wr_reg(FGD_CAP_DIV_ADDR, 8'h02);
      wr_reg(FGD_CAP_CTRL_ADDR, 8'h41);
      burst(8'h08, 4, 2);
      wr_reg(FGD_CAP_CTRL_ADDR, 8'h40);
      wr_reg(FGD_CAP_DIV_ADDR, 8'h00);
      wr_reg(FGD_DRM_DIV_ADDR, 8'h01);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h4a);
      // three edges: inverted, only the middle one counts as rising
      burst(8'h03, 3, 1);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h42);
      wr_reg(FGD_DRM_DIV_ADDR, 8'h00);
      burst(8'h01, 1, 1);
      wr_reg(FGD_CAP_DIV_ADDR, 8'h03);
      burst(8'h02, 0, 2);
      // rewrite restarts the count, so two more rises give no pulse
      wr_reg(FGD_CAP_DIV_ADDR, 8'h03);
      burst(8'h04, 0, 4);
      wr_reg(FGD_CAP_DIV_ADDR, 8'h00);
      $display("test divide done");
   endtask
   // mask of two slow ticks spans at most 2048 cycles; edges 41 apart fall inside it
   task automatic t_mask();
      wr_reg(FGD_CAP_MASK_ADDR, 8'h02);
      wr_reg(FGD_DRM_MASK_ADDR, 8'h02);
      burst(8'h04, 1, 1);
      rd_chk(FGD_CAP_CTRL_ADDR, 8'he0);
      rd_chk(FGD_DRM_CTRL_ADDR, 8'he2);
      repeat (2100) @(posedge clk);
      wr_reg(FGD_CAP_CTRL_ADDR, 8'h00);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h02);
      rd_chk(FGD_CAP_CTRL_ADDR, 8'h40);
      rd_chk(FGD_DRM_CTRL_ADDR, 8'h42);
      wr_reg(FGD_CAP_MASK_ADDR, 8'h00);
      wr_reg(FGD_DRM_MASK_ADDR, 8'h00);
      burst(8'h04, 4, 4);
      $display("test mask done");
   endtask
   task automatic t_ref();
      pulse_ref();
      rd_chk(FGD_DRM_CTRL_ADDR, 8'h46);
      wr_reg(FGD_DRM_CTRL_ADDR, 8'h40);
      rd_chk(FGD_DRM_CTRL_ADDR, 8'h42);
      wr_reg(FGD_REF_INIT_ADDR, 8'h01);
      wr_reg(FGD_DRM_DIV_ADDR, 8'h02);
      burst(8'h01, 1, 0);
      pulse_ref();
      // the reference edge dropped the one counted rise
      burst(8'h02, 2, 0);
      burst(8'h01, 1, 0);
      wr_reg(FGD_REF_INIT_ADDR, 8'h00);
      wr_reg(FGD_DRM_DIV_ADDR, 8'h00);
      $display("test reference done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #(25ns * 60000);
      failures++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_divide();
      t_mask();
      t_ref();
      stop_test();
   end
endmodule
`default_nettype wire
